//--- logic/ips_ahb_slave.sv
// AHB-Lite slave front end for the priority select register
`timescale 1ns/100ps
module ips_ahb_slave (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] rd_value,
   output logic wr_stb,
   output logic [7:0] wr_data
);
   // Slave state: pending write and registered read data
   typedef struct packed {
      logic wr_pend;
      logic [31:0] rdata;
   } ips_slv_st_t;

   ips_slv_st_t st_r;   // Registered state
   ips_slv_st_t st_nxt; // Next state
   logic acc;           // Address phase accepted
   logic hit;           // Address matches the register

   // Address phase decode
   always_comb begin
      acc = hsel && (htrans == ips_pkg::IPS_HTRANS_NONSEQ) && hready;
      hit = (haddr[ips_pkg::IPS_ADDR_W-1:0] == ips_pkg::IPS_PRIO_OFFSET)
         && (haddr[31:ips_pkg::IPS_ADDR_W] == '0);
   end

   // Next state: writes land in the data phase, reads are sampled now
   always_comb begin
      st_nxt = st_r;
      st_nxt.wr_pend = acc && hwrite && hit;
      if (acc && !hwrite) begin
         // Unmapped reads return zero
         if (hit) begin
            st_nxt.rdata = {24'h000000, rd_value};
         end else begin
            st_nxt.rdata = 32'h00000000;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero wait states, always OKAY; word-sized access assumed
   assign hreadyout = 1'b1;
   assign hresp = ips_pkg::IPS_HRESP_OKAY[0];
   assign hrdata = st_r.rdata;
   assign wr_stb = st_r.wr_pend;
   assign wr_data = hwdata[7:0];
endmodule

//--- logic/ips_pkg.sv
// Constants for the interrupt priority select register block
package ips_pkg;
   // Register map
   localparam int IPS_ADDR_W = 12;                     // Decoded address bits
   localparam logic [11:0] IPS_PRIO_OFFSET = 12'h0B8;   // Priority select register
   localparam logic [7:0] IPS_PRIO_RESET = 8'h80;       // Value after reset
   // Field positions
   localparam int IPS_BIT_EXT_A = 0;                    // First external input
   localparam int IPS_BIT_TIMER_FIRST = 1;              // First timer overflow
   localparam int IPS_BIT_EXT_B = 2;                    // Second external input
   localparam int IPS_BIT_TIMER_SECOND = 3;             // Companion timer
   localparam int IPS_BIT_SERIAL = 4;                   // Serial port
   localparam int IPS_BIT_TIMER_B = 5;                  // Second-numbered timer
   localparam int IPS_BIT_SPI = 6;                      // SPI port
   localparam int IPS_BIT_UNUSED = 7;                   // Always reads one
   localparam int IPS_NUM_SRC = 7;                      // Number of priority bits
   // Bus encodings
   localparam logic [1:0] IPS_HTRANS_NONSEQ = 2'h2;     // Start of a transfer
   localparam logic [1:0] IPS_HRESP_OKAY = 2'h0;        // Only answer given
endpackage

//--- logic/ips_top.sv
// Interrupt priority select register with AHB-Lite access
//
// What this block does
// - Bit 4 sets serial port priority level
// - Bit 2 sets second external input level
// - Bit 1 sets first timer priority level
// - Bit 0 sets first external input level
`timescale 1ns/100ps
module ips_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic spi_irq_high_level,
   output logic timer_b_irq_high_level,
   output logic serial_irq_high_level,
   output logic timer_second_irq_high_level,
   output logic ext_input_b_high_level,
   output logic timer_first_irq_high_level,
   output logic ext_input_a_high_level
);
   // Block state: the seven priority bits
   typedef struct packed {
      logic [ips_pkg::IPS_NUM_SRC-1:0] prio;
   } ips_st_t;

   ips_st_t st_r;        // Registered state
   ips_st_t st_nxt;      // Next state
   logic wr_stb;         // Register write in data phase
   logic [7:0] wr_data;  // Byte written
   logic [7:0] rd_value; // Value offered to a read

   // Bus front end
   ips_ahb_slave u_slave (
      .ref_clk(ref_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rd_value(rd_value),
      .wr_stb(wr_stb),
      .wr_data(wr_data)
   );

   // Next state: each of the low seven written bits maps to one source level
   always_comb begin
      st_nxt = st_r;
      if (wr_stb) begin
         // Top bit is a don't-care on write
         st_nxt.prio = wr_data[ips_pkg::IPS_NUM_SRC-1:0];
      end
   end

   // Read value, forwarding a write in flight so back-to-back reads see it
   always_comb begin
      if (wr_stb) begin
         rd_value = {1'b1, wr_data[ips_pkg::IPS_NUM_SRC-1:0]};
      end else begin
         rd_value = {1'b1, st_r.prio};
      end
   end

   // State register, reset leaves every source at low priority
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r.prio <= ips_pkg::IPS_PRIO_RESET[ips_pkg::IPS_NUM_SRC-1:0];
      end else begin
         st_r <= st_nxt;
      end
   end

   // Priority levels to the core, straight from flops
   assign serial_irq_high_level = st_r.prio[ips_pkg::IPS_BIT_SERIAL];
   assign ext_input_b_high_level = st_r.prio[ips_pkg::IPS_BIT_EXT_B];
   assign timer_first_irq_high_level = st_r.prio[ips_pkg::IPS_BIT_TIMER_FIRST];
   assign ext_input_a_high_level = st_r.prio[ips_pkg::IPS_BIT_EXT_A];
   assign spi_irq_high_level = st_r.prio[ips_pkg::IPS_BIT_SPI];
   assign timer_b_irq_high_level = st_r.prio[ips_pkg::IPS_BIT_TIMER_B];
   assign timer_second_irq_high_level = st_r.prio[ips_pkg::IPS_BIT_TIMER_SECOND];

   // Checks on the priority outputs and on the read-back data
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Write address phase to the register, seen one cycle later as a data phase
   sequence s_reg_write;
      hsel && htrans == ips_pkg::IPS_HTRANS_NONSEQ && hready && hwrite
         && haddr == {20'h00000, ips_pkg::IPS_PRIO_OFFSET};
   endsequence

   a_serial_level: assert property (s_reg_write ##1 1'b1 |=>
      serial_irq_high_level == $past(hwdata[4]))
      else $error("serial level does not follow written bit");
   a_ext_b_level: assert property (s_reg_write ##1 1'b1 |=>
      ext_input_b_high_level == $past(hwdata[2]))
      else $error("second external level does not follow written bit");
   a_timer_first_level: assert property (s_reg_write ##1 1'b1 |=>
      timer_first_irq_high_level == $past(hwdata[1]))
      else $error("first timer level does not follow written bit");
   a_ext_a_level: assert property (s_reg_write ##1 1'b1 |=>
      ext_input_a_high_level == $past(hwdata[0]))
      else $error("first external level does not follow written bit");
   a_other_levels: assert property (s_reg_write ##1 1'b1 |=>
      {spi_irq_high_level, timer_b_irq_high_level, timer_second_irq_high_level}
         == {$past(hwdata[6]), $past(hwdata[5]), $past(hwdata[3])})
      else $error("spi, timer b or companion timer level wrong");
   a_levels_hold: assert property (!wr_stb |=> $stable({spi_irq_high_level,
      timer_b_irq_high_level, serial_irq_high_level, timer_second_irq_high_level,
      ext_input_b_high_level, timer_first_irq_high_level, ext_input_a_high_level}))
      else $error("priority level changed without a write");
   a_read_back: assert property (hsel && htrans == ips_pkg::IPS_HTRANS_NONSEQ
      && hready && !hwrite && haddr == {20'h00000, ips_pkg::IPS_PRIO_OFFSET} && !wr_stb
      |=> hrdata == {24'h000000, 1'b1, $past(st_r.prio)})
      else $error("read value does not show priority bits and top one");
   a_read_top_one: assert property (hsel && htrans == ips_pkg::IPS_HTRANS_NONSEQ
      && hready && !hwrite && haddr == {20'h00000, ips_pkg::IPS_PRIO_OFFSET}
      |=> hrdata[ips_pkg::IPS_BIT_UNUSED] == 1'b1)
      else $error("unused top bit did not read one");

   c_write_reg: cover property (s_reg_write ##1 1'b1 ##1 serial_irq_high_level);
   c_read_reg: cover property (hsel && hready && !hwrite
      && htrans == ips_pkg::IPS_HTRANS_NONSEQ ##1 hrdata[6]);
   c_all_high: cover property (&st_r.prio);

   // Read taken right behind a write, served by the forwarding path
   c_back_to_back: cover property (wr_stb && hsel && hready && !hwrite
      && htrans == ips_pkg::IPS_HTRANS_NONSEQ);

   // Helper terms for the checks below
   logic rd_take;    // Read address phase taken this cycle
   logic reg_addr;   // Address points at the register
   logic wr_take;    // Write address phase taken this cycle

   // Decode of the address phase as the bus shows it
   assign rd_take = hsel && htrans == ips_pkg::IPS_HTRANS_NONSEQ && hready && !hwrite;
   assign wr_take = hsel && htrans == ips_pkg::IPS_HTRANS_NONSEQ && hready && hwrite;
   assign reg_addr = haddr == {20'h00000, ips_pkg::IPS_PRIO_OFFSET};

   // Bus answer never stalls
   a_ready_always: assert property (hreadyout == 1'b1)
      else $error("slave ready dropped");

   // Bus answer is always OKAY
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response not okay");

   // Serial level holds while no write lands
   a_serial_hold: assert property (!wr_stb |=> $stable(serial_irq_high_level))
      else $error("serial level moved without a write");

   // Second external level holds while no write lands
   a_ext_b_hold: assert property (!wr_stb |=> $stable(ext_input_b_high_level))
      else $error("second external level moved without a write");

   // First timer level holds while no write lands
   a_timer_first_hold: assert property (!wr_stb |=>
      $stable(timer_first_irq_high_level))
      else $error("first timer level moved without a write");

   // First external level holds while no write lands
   a_ext_a_hold: assert property (!wr_stb |=> $stable(ext_input_a_high_level))
      else $error("first external level moved without a write");

   // SPI level holds while no write lands
   a_spi_hold: assert property (!wr_stb |=> $stable(spi_irq_high_level))
      else $error("spi level moved without a write");

   // Timer B level holds while no write lands
   a_timer_b_hold: assert property (!wr_stb |=> $stable(timer_b_irq_high_level))
      else $error("timer b level moved without a write");

   // Companion timer level holds while no write lands
   a_timer_second_hold: assert property (!wr_stb |=>
      $stable(timer_second_irq_high_level))
      else $error("companion timer level moved without a write");

   // Serial source starts at low priority after reset
   a_serial_reset: assert property ($past(rst) |-> !serial_irq_high_level)
      else $error("serial level not low after reset");

   // Second external source starts low after reset
   a_ext_b_reset: assert property ($past(rst) |-> !ext_input_b_high_level)
      else $error("second external level not low after reset");

   // First timer starts low after reset
   a_timer_first_reset: assert property ($past(rst) |->
      !timer_first_irq_high_level)
      else $error("first timer level not low after reset");

   // First external source starts low after reset
   a_ext_a_reset: assert property ($past(rst) |-> !ext_input_a_high_level)
      else $error("first external level not low after reset");

   // Remaining three sources start low after reset
   a_other_reset: assert property ($past(rst) |->
      !(spi_irq_high_level || timer_b_irq_high_level || timer_second_irq_high_level))
      else $error("spi, timer b or companion level not low after reset");

   // Read data is clear right after reset
   a_reset_rdata: assert property ($past(rst) |-> hrdata == 32'h00000000)
      else $error("read data not clear after reset");

   // A read behind a write sees the byte in flight
   a_read_forward: assert property (rd_take && reg_addr && wr_stb |=>
      hrdata == {24'h000000, 1'b1, $past(wr_data[ips_pkg::IPS_NUM_SRC-1:0])})
      else $error("read behind a write missed the new value");

   // Reads elsewhere return zero
   a_unmapped_read: assert property (rd_take && !reg_addr |=> hrdata == 32'h00000000)
      else $error("unmapped read did not return zero");

   // Read data stands until the next read is taken
   a_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data changed without a read");

   // A register write raises the strobe in its data phase
   a_stb_follows: assert property (wr_take && reg_addr |=> wr_stb)
      else $error("write strobe missing in data phase");

   // The strobe only follows a register write
   a_no_stray_stb: assert property (wr_stb |-> $past(wr_take && reg_addr))
      else $error("write strobe without a register write");

   // Writes elsewhere leave the strobe low
   a_unmapped_write: assert property (wr_take && !reg_addr |=> !wr_stb)
      else $error("unmapped write raised the strobe");
endmodule

//--- verif/ips_core_model.sv
// Core-side model that gathers the seven priority levels into one vector
`timescale 1ns/100ps
module ips_core_model (
   input wire logic spi_irq_high_level,
   input wire logic timer_b_irq_high_level,
   input wire logic serial_irq_high_level,
   input wire logic timer_second_irq_high_level,
   input wire logic ext_input_b_high_level,
   input wire logic timer_first_irq_high_level,
   input wire logic ext_input_a_high_level,
   output logic [6:0] prio_vec
);
   // Each level lands at its register bit position; one means high priority
   assign prio_vec = {spi_irq_high_level, timer_b_irq_high_level, serial_irq_high_level,
      timer_second_irq_high_level, ext_input_b_high_level, timer_first_irq_high_level,
      ext_input_a_high_level};
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the priority select register
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
   logic ref_clk = 1'b0; // System clock
   logic rst = 1'b1; // Reset, active high
   logic hsel = 1'b0; // Slave select
   logic [31:0] haddr = 32'h0; // Byte address
   logic [1:0] htrans = 2'h0; // Transfer type
   logic hwrite = 1'b0; // Direction
   logic [2:0] hsize = 3'h2; // Always a word
   logic [31:0] hwdata = 32'h0; // Write data
   logic hreadyout; // Slave ready, also bus ready
   logic hresp; // Response
   logic [31:0] hrdata; // Read data
   logic l6, l5, l4, l3, l2, l1, l0; // Priority levels
   logic [6:0] prio_vec; // Levels as seen by the core
   logic [31:0] rd; // Last read word
   logic [31:0] reg_a = 32'(ips_pkg::IPS_PRIO_OFFSET); // Register byte address
   int num_errors = 0; // Mismatches
   int total_checks = 0; // Comparisons
   int cycles = 0; // Run length
   ips_top dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_irq_high_level(l6),
      .timer_b_irq_high_level(l5), .serial_irq_high_level(l4),
      .timer_second_irq_high_level(l3), .ext_input_b_high_level(l2),
      .timer_first_irq_high_level(l1), .ext_input_a_high_level(l0));
   ips_core_model core (.spi_irq_high_level(l6), .timer_b_irq_high_level(l5),
      .serial_irq_high_level(l4), .timer_second_irq_high_level(l3),
      .ext_input_b_high_level(l2), .timer_first_irq_high_level(l1),
      .ext_input_a_high_level(l0), .prio_vec(prio_vec));
   // Clock generator
   always #25 ref_clk = ~ref_clk;
   // Cuts a hung run short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("wrong value at %0t ns: run too long", $time);
         wrap_up();
      end
   end
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One single AHB-Lite transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rdv);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= ips_pkg::IPS_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
      #1;
      `CHK(hresp, ips_pkg::IPS_HRESP_OKAY)
   endtask
   // Sets one priority bit alone and checks word and levels
   task automatic one_bit(input int idx);
      ahb(1'b1, reg_a, 32'h1 << idx, rd);
      `CHK(prio_vec, 7'(1 << idx))
      ahb(1'b0, reg_a, 32'h0, rd);
      `CHK(rd, 32'h80 | (32'h1 << idx))
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      ahb(1'b0, reg_a, 32'h0, rd);
      `CHK(rd, {24'h0, ips_pkg::IPS_PRIO_RESET})
      `CHK(prio_vec, 7'h00)
      one_bit(4);
      one_bit(2);
      one_bit(1);
      one_bit(0);
      one_bit(6);
      one_bit(5);
      one_bit(3);
      // All seven bits high, top bit reads one
      ahb(1'b1, reg_a, 32'h7F, rd);
      ahb(1'b0, reg_a, 32'h0, rd);
      `CHK(rd, 32'hFF)
      `CHK(prio_vec, 7'h7F)
      // Unmapped place: write lost, read gives zero
      ahb(1'b1, reg_a + 32'h4, 32'h0, rd);
      ahb(1'b0, reg_a + 32'h4, 32'h0, rd);
      `CHK(rd, 32'h0)
      ahb(1'b0, reg_a, 32'h0, rd);
      `CHK(rd, 32'hFF)
      // Write then read back to back: forwarding path
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= reg_a;
      htrans <= ips_pkg::IPS_HTRANS_NONSEQ;
      hwrite <= 1'b1;
      @(posedge ref_clk);
      hwrite <= 1'b0;
      hwdata <= 32'h15;
      @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      @(posedge ref_clk);
      `CHK(hrdata, 32'h95)
      // Setting only the top bit on write leaves all seven levels low
      ahb(1'b1, reg_a, 32'h80, rd);
      `CHK(prio_vec, 7'h00)
      ahb(1'b1, reg_a, 32'h7F, rd);
      // Reset in mid-run brings back low levels
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK(prio_vec, 7'h00)
      ahb(1'b0, reg_a, 32'h0, rd);
      `CHK(rd, 32'h80)
      wrap_up();
   end
endmodule
